//--- design/arc_regs.sv
// Interrupt enable, operating state and sample rate control with SCL watchdog
`timescale 1ns/1ps
`default_nettype none
`include "arc_cfg.svh"

module arc_regs #(
    parameter int CLK_HZ  = `ARC_CLK_HZ,
    parameter int WDT_CYC = `ARC_WDT_CYC
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              LINK_CLK,
    input  wire arc_pkg::arc_req_t REG_REQ,
    output logic [7:0]             REG_RDATA,
    input  wire logic [7:0]        MOT_CTRL,
    input  wire arc_pkg::arc_src_t SRC_COND,
    input  wire logic              SCL_IN,
    input  wire logic              BUS_ACTIVE,
    output logic                   IRQ,
    output logic                   SAMPLE_TICK,
    output logic                   CLK_RUN,
    output logic                   SAMPLE_EN,
    output logic [2:0]             RATE_SEL,
    output logic                   BUS_IDLE_RST
);

    // ---------------- Link domain ----------------
    logic              rst_l_s1;
    logic              rst_l_q;
    logic [7:0]        inten_q;
    logic [7:0]        mode_q;
    logic [7:0]        rate_q;
    logic [10:0]       tl_s1;
    logic [10:0]       tl_q;
    logic              swr_l;
    logic              dsrd_l;

    // ---------------- Core domain ----------------
    logic [18:0]       cs_s1;
    logic [18:0]       cs_q;
    logic [7:0]        ie;
    logic [7:0]        md;
    logic [2:0]        rt;
    logic [7:0]        rpt_en;
    logic [7:0]        cond;
    logic [7:0]        set_v;
    logic [7:0]        clr_v;
    logic [7:0]        pend_q;
    logic              stat_wr_p;
    logic              rd_clr_p;
    arc_pkg::arc_state_t state_q;
    logic [1:0]        code;
    logic [`ARC_CNT_W-1:0] cnt_q;
    logic [`ARC_CNT_W-1:0] per;
    logic              scl_s1;
    logic              scl_q;
    logic              scl_p;
    logic              act_s1;
    logic              act_q;
    logic              stall;
    logic [`ARC_WDT_W-1:0] wdt_q;
    logic              tmo_p;
    logic              tmo_q;

    // Reset follows the core reset into the link domain; link clock must run
    // through a reset for the registers to take their reset values
    always_ff @(posedge LINK_CLK) begin
        rst_l_s1 <= RST;
        rst_l_q  <= rst_l_s1;
    end

    // Register writes, taken in any operating state
    always_ff @(posedge LINK_CLK) begin
        if (rst_l_q) begin
            inten_q <= `ARC_RST_INTEN;
            mode_q  <= `ARC_RST_MODE;
            rate_q  <= `ARC_RST_RATE;
        end else if (REG_REQ.we) begin
            if (REG_REQ.addr == `ARC_A_INTEN) begin
                inten_q <= REG_REQ.wdata & `ARC_INTEN_MASK;
            end
            if (REG_REQ.addr == `ARC_A_MODE) begin
                mode_q <= REG_REQ.wdata & `ARC_MODE_MASK;
            end
            if (REG_REQ.addr == `ARC_A_RATE) begin
                rate_q <= REG_REQ.wdata;
            end
        end
    end

    // Side-effect strobes: status write clears, device status read clears
    assign swr_l  = REG_REQ.we && (REG_REQ.addr == `ARC_A_ISTAT);
    assign dsrd_l = REG_REQ.re && (REG_REQ.addr == `ARC_A_DEVSTAT);

    // Status from the core, resynchronised; fields settle before a read
    always_ff @(posedge LINK_CLK) begin
        if (rst_l_q) begin
            tl_s1 <= 11'h000;
            tl_q  <= 11'h000;
        end else begin
            tl_s1 <= {tmo_q, code, pend_q};
            tl_q  <= tl_s1;
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge LINK_CLK) begin
        if (rst_l_q) begin
            REG_RDATA <= 8'h00;
        end else if (REG_REQ.re) begin
            unique case (REG_REQ.addr)
                `ARC_A_DEVSTAT: REG_RDATA <= {3'h0, tl_q[10], 2'h0, tl_q[9:8]};
                `ARC_A_INTEN:   REG_RDATA <= inten_q;
                `ARC_A_MODE:    REG_RDATA <= mode_q;
                `ARC_A_RATE:    REG_RDATA <= rate_q;
                `ARC_A_ISTAT:   REG_RDATA <= tl_q[7:0];
                default:        REG_RDATA <= 8'h00;
            endcase
        end
    end

    // Event crossings toward the core
    arc_pulse_xing u_swr_xing (
        .clk_a   (LINK_CLK),
        .rst_a   (rst_l_q),
        .pulse_a (swr_l),
        .clk_b   (CLK),
        .rst_b   (RST),
        .pulse_b (stat_wr_p)
    );

    arc_pulse_xing u_dsrd_xing (
        .clk_a   (LINK_CLK),
        .rst_a   (rst_l_q),
        .pulse_a (dsrd_l),
        .clk_b   (CLK),
        .rst_b   (RST),
        .pulse_b (rd_clr_p)
    );

    // Control levels into the core; quasi-static, so a multi-bit write may
    // show mixed old and new bits for one cycle only
    always_ff @(posedge CLK) begin
        if (RST) begin
            cs_s1 <= 19'h00000;
            cs_q  <= 19'h00000;
        end else begin
            cs_s1 <= {rate_q[2:0], mode_q, inten_q};
            cs_q  <= cs_s1;
        end
    end

    assign ie = cs_q[7:0];
    assign md = cs_q[15:8];
    assign rt = cs_q[18:16];

    // Source reporting gates; FIFO events never pass through here
    always_comb begin
        rpt_en = 8'h00;
        rpt_en[`ARC_B_TILT]  = ie[`ARC_B_TILT] & MOT_CTRL[`ARC_MC_TF];
        rpt_en[`ARC_B_FLIP]  = ie[`ARC_B_FLIP] & MOT_CTRL[`ARC_MC_TF];
        rpt_en[`ARC_B_ANYM]  = ie[`ARC_B_ANYM] & MOT_CTRL[`ARC_MC_ANYM];
        rpt_en[`ARC_B_SHAKE] = ie[`ARC_B_SHAKE] & MOT_CTRL[`ARC_MC_SHAKE]
                             & MOT_CTRL[`ARC_MC_ANYM];
        rpt_en[`ARC_B_T35]   = ie[`ARC_B_T35] & MOT_CTRL[`ARC_MC_T35]
                             & MOT_CTRL[`ARC_MC_ANYM];
        rpt_en[`ARC_B_ACQ]   = ie[`ARC_B_ACQ];
    end

    // Conditions per status bit; the sample tick is the acquisition source
    always_comb begin
        cond = 8'h00;
        cond[`ARC_B_TILT]  = SRC_COND.tilt;
        cond[`ARC_B_FLIP]  = SRC_COND.flip;
        cond[`ARC_B_ANYM]  = SRC_COND.anym;
        cond[`ARC_B_SHAKE] = SRC_COND.shake;
        cond[`ARC_B_T35]   = SRC_COND.tilt35;
        cond[`ARC_B_ACQ]   = SAMPLE_TICK;
    end

    assign set_v = cond & rpt_en;
    // Self-clear drops a flag once its cause is gone, else wait for a write
    assign clr_v = ie[`ARC_B_ACLR] ? ~cond : {8{stat_wr_p}};

    // Pending flags; a new event beats a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            pend_q <= 8'h00;
        end else begin
            pend_q <= set_v | (pend_q & ~clr_v);
        end
    end

    // Interrupt pin follows pending flags that are still enabled
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(pend_q & rpt_en);
        end
    end

    // Operating state; the reserved code leaves the state as it was
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= arc_pkg::ARC_SLEEP;
        end else begin
            unique case (md[1:0])
                `ARC_CODE_SLEEP: state_q <= arc_pkg::ARC_SLEEP;
                `ARC_CODE_WAKE:  state_q <= arc_pkg::ARC_WAKE;
                `ARC_CODE_STBY:  state_q <= arc_pkg::ARC_STBY;
                `ARC_CODE_RSVD:  state_q <= state_q;
            endcase
        end
    end

    // State code as reported in device status
    always_comb begin
        unique case (state_q)
            arc_pkg::ARC_SLEEP: code = `ARC_CODE_SLEEP;
            arc_pkg::ARC_WAKE:  code = `ARC_CODE_WAKE;
            arc_pkg::ARC_STBY:  code = `ARC_CODE_STBY;
            default:            code = `ARC_CODE_SLEEP;
        endcase
    end

    // Clock run and sampling enables from the state
    always_ff @(posedge CLK) begin
        if (RST) begin
            CLK_RUN   <= 1'b0;
            SAMPLE_EN <= 1'b0;
        end else begin
            CLK_RUN   <= (state_q != arc_pkg::ARC_SLEEP);
            SAMPLE_EN <= (state_q == arc_pkg::ARC_WAKE);
        end
    end

    // Oscillator select follows the rate code
    always_ff @(posedge CLK) begin
        if (RST) begin
            RATE_SEL <= 3'h0;
        end else begin
            RATE_SEL <= rt;
        end
    end

    // Sample period in core cycles for each rate code
    function automatic logic [`ARC_CNT_W-1:0] period(input logic [2:0] c);
        int hz;
        unique case (c)
            3'h0: hz = `ARC_HZ0;
            3'h1: hz = `ARC_HZ1;
            3'h2: hz = `ARC_HZ2;
            3'h3: hz = `ARC_HZ3;
            3'h4: hz = `ARC_HZ4;
            3'h5: hz = `ARC_HZ5;
            3'h6: hz = `ARC_HZ6;
            3'h7: hz = `ARC_HZ7;
        endcase
        return `ARC_CNT_W'(CLK_HZ / hz);
    endfunction

    assign per = period(rt);

    // Sample tick while awake; >= lets a faster rate restart at once
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_q       <= `ARC_CNT_W'h0;
            SAMPLE_TICK <= 1'b0;
        end else if (state_q != arc_pkg::ARC_WAKE) begin
            cnt_q       <= `ARC_CNT_W'h0;
            SAMPLE_TICK <= 1'b0;
        end else if (cnt_q >= per - `ARC_CNT_W'h1) begin
            cnt_q       <= `ARC_CNT_W'h0;
            SAMPLE_TICK <= 1'b1;
        end else begin
            cnt_q       <= cnt_q + `ARC_CNT_W'h1;
            SAMPLE_TICK <= 1'b0;
        end
    end

    // Bus pins sampled through two flops before use
    always_ff @(posedge CLK) begin
        if (RST) begin
            scl_s1 <= 1'b1;
            scl_q  <= 1'b1;
            scl_p  <= 1'b1;
            act_s1 <= 1'b0;
            act_q  <= 1'b0;
        end else begin
            scl_s1 <= SCL_IN;
            scl_q  <= scl_s1;
            scl_p  <= scl_q;
            act_s1 <= BUS_ACTIVE;
            act_q  <= act_s1;
        end
    end

    // A stall counts only inside a transfer; an idle bus sits high legally
    assign stall = act_q & ((md[`ARC_B_GLOW] & ~scl_q)
                 | (md[`ARC_B_GHIGH] & scl_q));

    // Stall length counter saturates so one stall fires only once
    always_ff @(posedge CLK) begin
        if (RST) begin
            wdt_q <= `ARC_WDT_W'h0;
        end else if (!stall || (scl_q != scl_p)) begin
            wdt_q <= `ARC_WDT_W'h0;
        end else if (wdt_q != `ARC_WDT_W'(WDT_CYC)) begin
            wdt_q <= wdt_q + `ARC_WDT_W'h1;
        end
    end

    assign tmo_p = stall && (scl_q == scl_p)
                && (wdt_q == `ARC_WDT_W'(WDT_CYC - 1));

    // Idle request to the slave engine and sticky flag; set beats read-clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            BUS_IDLE_RST <= 1'b0;
            tmo_q        <= 1'b0;
        end else begin
            BUS_IDLE_RST <= tmo_p;
            tmo_q        <= tmo_p | (tmo_q & ~rd_clr_p);
        end
    end

    // ---------------- Checks ----------------
    a_irq_follows_set: assert property (@(posedge CLK) disable iff (RST)
        (|set_v) ##1 ($stable(rpt_en) && $stable(MOT_CTRL)) |=> IRQ)
        else $error("interrupt not raised two cycles after a reported event");

    a_tilt_gate: assert property (@(posedge CLK) disable iff (RST)
        $rose(pend_q[`ARC_B_TILT]) |->
            $past(ie[`ARC_B_TILT] && MOT_CTRL[`ARC_MC_TF]))
        else $error("tilt flag set without both enables");

    a_shake_gate: assert property (@(posedge CLK) disable iff (RST)
        $rose(pend_q[`ARC_B_SHAKE]) |->
            $past(MOT_CTRL[`ARC_MC_SHAKE] && MOT_CTRL[`ARC_MC_ANYM]))
        else $error("shake flag set without shake and any-motion features");

    a_manual_hold: assert property (@(posedge CLK) disable iff (RST)
        pend_q[`ARC_B_FLIP] && !ie[`ARC_B_ACLR] && !stat_wr_p
            |=> pend_q[`ARC_B_FLIP])
        else $error("pending flag lost without a status write");

    a_self_clear: assert property (@(posedge CLK) disable iff (RST)
        ie[`ARC_B_ACLR] && pend_q[`ARC_B_ANYM] && !cond[`ARC_B_ANYM]
            |=> !pend_q[`ARC_B_ANYM])
        else $error("self-clear did not drop a stale flag");

    a_acq_flag: assert property (@(posedge CLK) disable iff (RST)
        SAMPLE_TICK && ie[`ARC_B_ACQ] |=> pend_q[`ARC_B_ACQ])
        else $error("sample-done flag not set after a sample");

    a_tick_only_wake: assert property (@(posedge CLK) disable iff (RST)
        SAMPLE_TICK |-> $past(state_q == arc_pkg::ARC_WAKE))
        else $error("sample taken outside wake");

    a_sleep_quiet: assert property (@(posedge CLK) disable iff (RST)
        state_q == arc_pkg::ARC_SLEEP |=> !CLK_RUN && !SAMPLE_EN)
        else $error("clocks or sampling active in sleep");

    a_stby_clocks: assert property (@(posedge CLK) disable iff (RST)
        state_q == arc_pkg::ARC_STBY |=> CLK_RUN && !SAMPLE_EN)
        else $error("standby outputs wrong");

    a_wdt_fire: assert property (@(posedge CLK) disable iff (RST)
        tmo_p |=> BUS_IDLE_RST && tmo_q ##1 !BUS_IDLE_RST)
        else $error("timeout did not give one idle pulse and a flag");

    a_wdt_off: assert property (@(posedge CLK) disable iff (RST)
        !md[`ARC_B_GLOW] && !md[`ARC_B_GHIGH] |-> !tmo_p)
        else $error("watchdog fired while both guards off");

    a_tmo_clear: assert property (@(posedge CLK) disable iff (RST)
        rd_clr_p && !tmo_p |=> !tmo_q)
        else $error("status read did not clear the timeout flag");

    a_mode_write: assert property (@(posedge LINK_CLK) disable iff (rst_l_q)
        REG_REQ.we && REG_REQ.addr == `ARC_A_MODE
            |=> mode_q == ($past(REG_REQ.wdata) & `ARC_MODE_MASK))
        else $error("mode write not accepted");

    c_irq_rise: cover property (@(posedge CLK) disable iff (RST) $rose(IRQ));
    c_wake_tick: cover property (@(posedge CLK) disable iff (RST) SAMPLE_TICK);
    c_timeout: cover property (@(posedge CLK) disable iff (RST) tmo_p);
    c_self_clear: cover property (@(posedge CLK) disable iff (RST)
        ie[`ARC_B_ACLR] && $fell(pend_q[`ARC_B_ANYM]));

endmodule

`default_nettype wire

//--- design/arc_cfg.svh
// Constants for the interrupt-enable, operating-state and sample-rate control block
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

// Register addresses
`define ARC_A_DEVSTAT  8'h05
`define ARC_A_INTEN    8'h06
`define ARC_A_MODE     8'h07
`define ARC_A_RATE     8'h08
`define ARC_A_ISTAT    8'h14

// Reset values and writable-bit masks
`define ARC_RST_INTEN  8'h00
`define ARC_RST_MODE   8'h00
`define ARC_RST_RATE   8'h00
`define ARC_INTEN_MASK 8'hdf
`define ARC_MODE_MASK  8'h33

// Interrupt enable and status bit positions
`define ARC_B_TILT     0
`define ARC_B_FLIP     1
`define ARC_B_ANYM     2
`define ARC_B_SHAKE    3
`define ARC_B_T35      4
`define ARC_B_ACLR     6
`define ARC_B_ACQ      7

// Motion control bit positions
`define ARC_MC_TF      0
`define ARC_MC_ANYM    2
`define ARC_MC_SHAKE   3
`define ARC_MC_T35     4

// Operating-state fields and codes
`define ARC_B_GLOW     4
`define ARC_B_GHIGH    5
`define ARC_CODE_SLEEP 2'h0
`define ARC_CODE_WAKE  2'h1
`define ARC_CODE_RSVD  2'h2
`define ARC_CODE_STBY  2'h3
`define ARC_B_DS_WDT   4

// Sample rates in Hz per code
`define ARC_HZ0        50
`define ARC_HZ1        100
`define ARC_HZ2        125
`define ARC_HZ3        200
`define ARC_HZ4        250
`define ARC_HZ5        500
`define ARC_HZ6        1000
`define ARC_HZ7        2000

// Clock rate, counter widths, watchdog stall length
`define ARC_CLK_HZ     40000000
`define ARC_CNT_W      20
`define ARC_WDT_W      16
`define ARC_WDT_CYC    4000

`endif

//--- design/arc_pkg.sv
// Types shared by the control block and its bench
package arc_pkg;

    // One-hot operating states
    typedef enum logic [2:0] {
        ARC_SLEEP = 3'b001,
        ARC_WAKE  = 3'b010,
        ARC_STBY  = 3'b100
    } arc_state_t;

    // Raw conditions from the motion detectors
    typedef struct packed {
        logic tilt35;
        logic shake;
        logic anym;
        logic flip;
        logic tilt;
    } arc_src_t;

    // Register request from the serial protocol engine
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arc_req_t;

endpackage

//--- design/arc_pulse_xing.sv
// Toggle-based single-pulse crossing between two clock domains
`timescale 1ns/1ps
`default_nettype none

module arc_pulse_xing (
    input  wire logic clk_a,
    input  wire logic rst_a,
    input  wire logic pulse_a,
    input  wire logic clk_b,
    input  wire logic rst_b,
    output logic      pulse_b
);
    logic tog_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Source side flips a level per event, so no pulse is too short to see
    always_ff @(posedge clk_a) begin
        if (rst_a) begin
            tog_q <= 1'b0;
        end else if (pulse_a) begin
            tog_q <= ~tog_q;
        end
    end

    // Two-stage synchroniser plus one stage for edge detection
    always_ff @(posedge clk_b) begin
        if (rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= tog_q;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign pulse_b = s2_q ^ s3_q;

endmodule

`default_nettype wire

//--- testbench/arc_host_model.sv
// Host-side model issuing single register accesses on the link clock
`timescale 1ns/1ps
`default_nettype none

module arc_host_model (
    input  wire logic              LINK_CLK,
    input  wire logic              go,
    input  wire arc_pkg::arc_req_t cmd,
    input  wire logic [7:0]        rdata_in,
    output arc_pkg::arc_req_t      req,
    output logic                   done,
    output logic [7:0]             rdata
);
    logic [1:0] ph = 2'd0;

    initial begin
        req = '0;
        done = 1'b0;
        rdata = 8'h00;
    end

    // One strobe per go level; released lines show the inverse so stale values never match
    always @(posedge LINK_CLK) begin
        case (ph)
            2'd0: if (go) begin
                req <= cmd;
                ph <= 2'd1;
            end
            2'd1: begin
                req <= '{we: 1'b0, re: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
                ph <= 2'd2;
            end
            2'd2: begin
                rdata <= rdata_in;
                done <= 1'b1;
                ph <= 2'd3;
            end
            default: if (!go) begin
                done <= 1'b0;
                ph <= 2'd0;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the interrupt enable, operating state and rate control block
`timescale 1ns/1ps
`default_nettype none
`include "arc_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module testbench;
    localparam int CLK_HZ  = 40000;
    localparam int WDT_CYC = 20;
    logic              clk = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst = 1'b1;
    logic              scl = 1'b1;
    logic              bus_act = 1'b0;
    logic              go = 1'b0;
    logic [7:0]        mot = 8'h00;
    arc_pkg::arc_src_t src = '0;
    arc_pkg::arc_req_t cmd = '0;
    arc_pkg::arc_req_t req;
    logic [7:0]        reg_rdata, host_rdata, rd;
    logic [2:0]        rate_sel;
    logic              irq, tick, clk_run, samp_en, idle_rst, done;
    int                mismatches = 0;
    int                samples_checked = 0;
    int                n;
    int                hz[8] = '{`ARC_HZ0, `ARC_HZ1, `ARC_HZ2, `ARC_HZ3,
                                 `ARC_HZ4, `ARC_HZ5, `ARC_HZ6, `ARC_HZ7};
    logic [7:0]        need[5] = '{8'h01, 8'h01, 8'h04, 8'h0c, 8'h14};
    logic [7:0]        mcode[4] = '{8'h01, 8'h03, 8'h02, 8'h00};
    logic [3:0]        mexp[4] = '{4'b1101, 4'b1011, 4'b1011, 4'b0000};

    // Core clock; link clock offset so the two never share an edge pattern
    always #12.5 clk = ~clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    arc_regs #(.CLK_HZ(CLK_HZ), .WDT_CYC(WDT_CYC)) arc_regs_i (
        .CLK(clk), .RST(rst), .LINK_CLK(link_clk), .REG_REQ(req), .REG_RDATA(reg_rdata),
        .MOT_CTRL(mot), .SRC_COND(src), .SCL_IN(scl), .BUS_ACTIVE(bus_act), .IRQ(irq),
        .SAMPLE_TICK(tick), .CLK_RUN(clk_run), .SAMPLE_EN(samp_en), .RATE_SEL(rate_sel),
        .BUS_IDLE_RST(idle_rst));

    arc_host_model arc_host_model_i (
        .LINK_CLK(link_clk), .go(go), .cmd(cmd), .rdata_in(reg_rdata), .req(req),
        .done(done), .rdata(host_rdata));

    // Full four-phase exchange with the host model, bounded against a stuck handshake
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cmd = '{we: w, re: ~w, addr: a, wdata: d};
        go = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        rd = host_rdata;
        go = 1'b0;
        while (done !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) mismatches++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK(rd, e)
    endtask

    task automatic waitc(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic irq_within(input logic e, input int c);
        n = 0;
        while (irq !== e && n < c) begin
            @(negedge clk);
            n++;
        end
        `CHK(irq, e)
    endtask

    // Cycles from the previous sample pulse to the next one
    task automatic tick_gap();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 2000);
    endtask

    task automatic guard_wait();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (idle_rst !== 1'b1 && n < WDT_CYC + 20);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Runs well past the longest expected sequence
    initial begin
        #(25.0 * 60000);
        mismatches++;
        close_out();
    end

    initial begin
        waitc(6);
        rst = 1'b0;
        waitc(6);
        rdchk(`ARC_A_INTEN, `ARC_RST_INTEN);
        rdchk(`ARC_A_MODE, `ARC_RST_MODE);
        rdchk(`ARC_A_RATE, `ARC_RST_RATE);
        rdchk(8'h30, 8'h00);
        wr(`ARC_A_INTEN, 8'hff);
        rdchk(`ARC_A_INTEN, 8'hdf);
        wr(`ARC_A_INTEN, 8'h00);
        $display("test reset and access done");
        // Every rate code, period measured after the counter has settled
        wr(`ARC_A_MODE, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(`ARC_A_RATE, 8'h08 | i[7:0]);
            rdchk(`ARC_A_RATE, 8'h08 | i[7:0]);
            `CHK(rate_sel, i[2:0])
            repeat (3) tick_gap();
            `CHK(n, CLK_HZ / hz[i])
        end
        $display("test sample rates done");
        for (int i = 0; i < 4; i++) begin
            wr(`ARC_A_MODE, mcode[i]);
            waitc(4);
            `CHK({clk_run, samp_en}, mexp[i][3:2])
            rdchk(`ARC_A_DEVSTAT, {6'h00, mexp[i][1:0]});
        end
        $display("test states done");
        // Each source: partial feature set must hold it off, full set reports it
        for (int i = 0; i < 5; i++) begin
            wr(`ARC_A_INTEN, 8'h01 << i);
            mot = need[i] & (need[i] - 8'h01);
            src = arc_pkg::arc_src_t'(5'h01 << i);
            waitc(6);
            `CHK(irq, 1'b0)
            mot = need[i];
            irq_within(1'b1, 8);
            rdchk(`ARC_A_ISTAT, 8'h01 << i);
            src = '0;
            waitc(6);
            `CHK(irq, 1'b1)
            wr(`ARC_A_ISTAT, 8'h00);
            irq_within(1'b0, 8);
        end
        // Self-clear is on here, first with the tilt source and then with the sample-done flag
        wr(`ARC_A_INTEN, 8'h41);
        mot = 8'h01;
        src = 5'h01;
        irq_within(1'b1, 8);
        src = '0;
        irq_within(1'b0, 8);
        wr(`ARC_A_MODE, 8'h01);
        wr(`ARC_A_INTEN, 8'hc0);
        tick_gap();
        irq_within(1'b1, 4);
        irq_within(1'b0, 4);
        wr(`ARC_A_INTEN, 8'h00);
        $display("test interrupts done");
        wr(`ARC_A_MODE, 8'h11);
        bus_act = 1'b1;
        scl = 1'b0;
        guard_wait();
        `CHK(idle_rst, 1'b1)
        rdchk(`ARC_A_DEVSTAT, 8'h11);
        // Read-clear crosses to the core and the flag crosses back before the next look
        waitc(8);
        rdchk(`ARC_A_DEVSTAT, 8'h01);
        wr(`ARC_A_MODE, 8'h21);
        scl = 1'b1;
        guard_wait();
        `CHK(idle_rst, 1'b1)
        scl = 1'b0;
        guard_wait();
        `CHK(idle_rst, 1'b0)
        $display("test bus guards done");
        close_out();
    end
endmodule
`default_nettype wire
